// ==== core/i2cpe_regs.vh ====
`ifndef I2CPE_REGS_VH
`define I2CPE_REGS_VH

// Bus identity and packet layout
`define I2CPE_TARGET_ID 7'h60
`define I2CPE_CW_OP_BIT 23
`define I2CPE_CW_CRC_BIT 22
`define I2CPE_CW_LEN_HI 21
`define I2CPE_CW_LEN_LO 20
`define I2CPE_CW_ADDR_HI 19
`define I2CPE_CW_ADDR_LO 0
`define I2CPE_CTRL_BYTES 2'h3

// Length codes
`define I2CPE_LEN_16 2'h0
`define I2CPE_LEN_32 2'h1
`define I2CPE_LEN_64 2'h2
`define I2CPE_LEN_RSVD 2'h3

// Second word of a 64-bit access
`define I2CPE_ADDR2_STEP 20'h00002

// CRC, x^8 + x^2 + x + 1
`define I2CPE_CRC_POLY 8'h07
`define I2CPE_CRC_INIT 8'hff

// Stretch timeout
`define I2CPE_STRETCH_TIMEOUT_US 5000
`define I2CPE_CLK_KHZ 10000

`endif

// ==== core/i2cpe_crc8.v ====
`include "i2cpe_regs.vh"
`default_nettype none

module i2cpe_crc8 (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Byte feed
  input wire init,
  input wire feed,
  input wire [7:0] din,
  // Running code
  output reg [7:0] crc
);

  function [7:0] i2cpe_step;
    input [7:0] acc;
    input [7:0] data;
    integer i;
    reg [7:0] c;
    begin
      c = acc ^ data;
      for (i = 0; i < 8; i = i + 1) begin
        c = c[7] ? ((c << 1) ^ `I2CPE_CRC_POLY) : (c << 1);
      end
      i2cpe_step = c;
    end
  endfunction

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      crc <= `I2CPE_CRC_INIT;
    end else if (feed) begin
      crc <= i2cpe_step(init ? `I2CPE_CRC_INIT : crc, din);
    end
  end

endmodule // i2cpe_crc8

`default_nettype wire

// ==== core/i2cpe_engine.v ====
`include "i2cpe_regs.vh"
`default_nettype none

module i2cpe_engine #(
  parameter STRETCH_CYCLES = `I2CPE_STRETCH_TIMEOUT_US * `I2CPE_CLK_KHZ / 1000
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Bus pins
  input wire scl_i,
  output reg scl_o,
  output reg scl_oe,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe,
  // Start event
  output reg start_pend,
  input wire start_svc,
  // Receive event
  output reg rx_pend,
  output reg [7:0] rx_byte,
  input wire rx_svc,
  // Transmit buffer fill
  output reg rd_req,
  output reg [19:0] rd_addr,
  input wire [31:0] rd_data,
  input wire rd_load,
  // Memory write
  output reg mem_wr_en,
  output reg [19:0] mem_wr_addr,
  output reg [31:0] mem_wr_data
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_RX = 3'h1;
  localparam [2:0] ST_HOLD = 3'h2;
  localparam [2:0] ST_ACK = 3'h3;
  localparam [2:0] ST_TXLD = 3'h4;
  localparam [2:0] ST_TX = 3'h5;
  localparam [2:0] ST_MACK = 3'h6;
  localparam [2:0] ST_SKIP = 3'h7;
  // Counter width covers the default 5 ms at 10 MHz
  localparam integer TMO_INT = STRETCH_CYCLES - 1;
  localparam [16:0] TMO_LAST = TMO_INT[16:0];

  function [3:0] i2cpe_len_bytes;
    input [1:0] code;
    begin
      case (code)
        `I2CPE_LEN_16: i2cpe_len_bytes = 4'h2;
        `I2CPE_LEN_32: i2cpe_len_bytes = 4'h4;
        `I2CPE_LEN_64: i2cpe_len_bytes = 4'h8;
        default: i2cpe_len_bytes = 4'h0;
      endcase
    end
  endfunction

  reg scl_m_reg, scl_s_reg, scl_q_reg;
  reg sda_m_reg, sda_s_reg, sda_q_reg;
  reg [2:0] state_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] sh_reg;
  reg addr_phase_reg, rd_mode_reg, wr_act_reg, crc_ok_reg, nak_reg;
  reg [1:0] ctrl_cnt_reg;
  reg [23:0] ctrl_reg;
  reg [3:0] data_cnt_reg, tx_idx_reg;
  reg [63:0] data_buf_reg;
  reg [31:0] tx_word_reg;
  reg word_ok_reg, wr_second_reg;
  reg [16:0] tmo_cnt_reg;
  reg crc_feed_reg, crc_init_reg;
  reg [7:0] crc_byte_reg;
  wire [7:0] crc_w;

  i2cpe_crc8 u_crc (
    .clk(clk),
    .rst(rst),
    .init(crc_init_reg),
    .feed(crc_feed_reg),
    .din(crc_byte_reg),
    .crc(crc_w)
  );

  // Edges seen only past the second sync stage
  wire scl_rise = scl_s_reg & ~scl_q_reg;
  wire scl_fall = ~scl_s_reg & scl_q_reg;
  wire start_det = scl_s_reg & scl_q_reg & sda_q_reg & ~sda_s_reg;
  wire stop_det = scl_s_reg & scl_q_reg & ~sda_q_reg & sda_s_reg;

  wire [1:0] len_code = ctrl_reg[`I2CPE_CW_LEN_HI:`I2CPE_CW_LEN_LO];
  wire [19:0] base_addr = ctrl_reg[`I2CPE_CW_ADDR_HI:`I2CPE_CW_ADDR_LO];
  wire op_read = ctrl_reg[`I2CPE_CW_OP_BIT];
  wire crc_on = ctrl_reg[`I2CPE_CW_CRC_BIT];
  wire [3:0] n_bytes = i2cpe_len_bytes(len_code);
  wire [3:0] wr_expect = n_bytes + {3'h0, crc_on};

  // reserved length gives no data bytes
  wire tx_data = op_read && (tx_idx_reg < n_bytes);
  wire tx_crc = op_read && crc_on && (n_bytes != 4'h0) && (tx_idx_reg == n_bytes);
  wire [7:0] tx_byte = tx_data ? tx_word_reg[{tx_idx_reg[1:0], 3'b000} +: 8] :
                       (tx_crc ? crc_w : 8'hff);

  // commit only with good length and CRC
  wire wr_good = wr_act_reg && !op_read && (ctrl_cnt_reg == `I2CPE_CTRL_BYTES) &&
                 (n_bytes != 4'h0) && (data_cnt_reg == wr_expect) && (!crc_on || crc_ok_reg);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_m_reg <= 1'b1;
      scl_s_reg <= 1'b1;
      scl_q_reg <= 1'b1;
      sda_m_reg <= 1'b1;
      sda_s_reg <= 1'b1;
      sda_q_reg <= 1'b1;
    end else begin
      scl_m_reg <= scl_i;
      scl_s_reg <= scl_m_reg;
      scl_q_reg <= scl_s_reg;
      sda_m_reg <= sda_i;
      sda_s_reg <= sda_m_reg;
      sda_q_reg <= sda_s_reg;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      start_pend <= 1'b0;
      rx_pend <= 1'b0;
      rx_byte <= 8'h00;
      rd_req <= 1'b0;
      rd_addr <= 20'h00000;
      mem_wr_en <= 1'b0;
      mem_wr_addr <= 20'h00000;
      mem_wr_data <= 32'h00000000;
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      addr_phase_reg <= 1'b0;
      rd_mode_reg <= 1'b0;
      wr_act_reg <= 1'b0;
      crc_ok_reg <= 1'b0;
      nak_reg <= 1'b0;
      ctrl_cnt_reg <= 2'h0;
      ctrl_reg <= 24'h000000;
      data_cnt_reg <= 4'h0;
      tx_idx_reg <= 4'h0;
      data_buf_reg <= 64'h0;
      tx_word_reg <= 32'h00000000;
      word_ok_reg <= 1'b0;
      wr_second_reg <= 1'b0;
      tmo_cnt_reg <= 17'h00000;
      crc_feed_reg <= 1'b0;
      crc_init_reg <= 1'b0;
      crc_byte_reg <= 8'h00;
    end else begin
      crc_feed_reg <= 1'b0;
      crc_init_reg <= 1'b0;
      mem_wr_en <= 1'b0;
      if (start_svc && !rx_pend) begin
        start_pend <= 1'b0;
      end
      if (rx_svc) begin
        rx_pend <= 1'b0;
      end
      if (rd_load && rd_req) begin
        tx_word_reg <= rd_data;
        word_ok_reg <= 1'b1;
        rd_req <= 1'b0;
      end
      // second word at address plus two
      if (wr_second_reg) begin
        mem_wr_en <= 1'b1;
        mem_wr_addr <= base_addr + `I2CPE_ADDR2_STEP;
        mem_wr_data <= data_buf_reg[63:32];
        wr_second_reg <= 1'b0;
      end
      tmo_cnt_reg <= scl_oe ? tmo_cnt_reg + 17'h1 : 17'h0;
      if (start_det || stop_det) begin
        if (wr_good) begin
          mem_wr_en <= 1'b1;
          mem_wr_addr <= base_addr;
          mem_wr_data <= (len_code == `I2CPE_LEN_16) ? {16'h0000, data_buf_reg[15:0]} :
                         data_buf_reg[31:0];
          wr_second_reg <= (len_code == `I2CPE_LEN_64);
        end
        wr_act_reg <= 1'b0;
        sda_oe <= 1'b0;
        scl_oe <= 1'b0;
        bit_cnt_reg <= 4'h0;
        addr_phase_reg <= 1'b1;
        state_reg <= start_det ? ST_RX : ST_IDLE;
      end else if (scl_oe && tmo_cnt_reg == TMO_LAST) begin
        scl_oe <= 1'b0;
        sda_oe <= 1'b0;
        wr_act_reg <= 1'b0;
        start_pend <= 1'b0;
        rd_req <= 1'b0;
        state_reg <= ST_SKIP;
      end else begin
        case (state_reg)
          ST_RX: begin
            if (scl_rise) begin
              sh_reg <= {sh_reg[6:0], sda_s_reg};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
            if (scl_fall && bit_cnt_reg == 4'h8) begin
              if (addr_phase_reg && sh_reg[7:1] != `I2CPE_TARGET_ID) begin
                state_reg <= ST_SKIP;
              end else begin
                state_reg <= ST_HOLD;
                scl_oe <= 1'b1;
                if (addr_phase_reg) begin
                  start_pend <= 1'b1;
                end
              end
            end
          end
          ST_HOLD: begin
            if (addr_phase_reg) begin
              if (!start_pend) begin
                addr_phase_reg <= 1'b0;
                rd_mode_reg <= sh_reg[0];
                crc_feed_reg <= 1'b1;
                crc_init_reg <= ~sh_reg[0];
                crc_byte_reg <= sh_reg;
                if (!sh_reg[0]) begin
                  wr_act_reg <= 1'b1;
                  ctrl_cnt_reg <= 2'h0;
                  data_cnt_reg <= 4'h0;
                  crc_ok_reg <= 1'b0;
                end else begin
                  tx_idx_reg <= 4'h0;
                  word_ok_reg <= 1'b0;
                end
                sda_oe <= 1'b1;
                scl_oe <= 1'b0;
                state_reg <= ST_ACK;
              end
            end else if (!rx_pend) begin
              rx_byte <= sh_reg;
              rx_pend <= 1'b1;
              if (ctrl_cnt_reg != `I2CPE_CTRL_BYTES) begin
                ctrl_reg <= {ctrl_reg[15:0], sh_reg};
                ctrl_cnt_reg <= ctrl_cnt_reg + 2'h1;
                crc_feed_reg <= 1'b1;
                crc_byte_reg <= sh_reg;
              end else begin
                if (crc_on && data_cnt_reg == n_bytes) begin
                  crc_ok_reg <= (sh_reg == crc_w);
                end else begin
                  crc_feed_reg <= 1'b1;
                  crc_byte_reg <= sh_reg;
                end
                if (data_cnt_reg < 4'h8) begin
                  data_buf_reg[{data_cnt_reg[2:0], 3'b000} +: 8] <= sh_reg;
                end
                if (data_cnt_reg != 4'hf) begin
                  data_cnt_reg <= data_cnt_reg + 4'h1;
                end
              end
              sda_oe <= 1'b1;
              scl_oe <= 1'b0;
              state_reg <= ST_ACK;
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              sda_oe <= 1'b0;
              bit_cnt_reg <= 4'h0;
              // read data follows the read address
              if (rd_mode_reg) begin
                state_reg <= ST_TXLD;
                scl_oe <= 1'b1;
              end else begin
                state_reg <= ST_RX;
              end
            end
          end
          ST_TXLD: begin
            if (tx_data && !word_ok_reg) begin
              if (!rd_req) begin
                rd_req <= 1'b1;
                rd_addr <= tx_idx_reg[2] ? base_addr + `I2CPE_ADDR2_STEP : base_addr;
              end
            end else begin
              if (tx_data) begin
                crc_feed_reg <= 1'b1;
                crc_byte_reg <= tx_byte;
                if (tx_idx_reg[1:0] == 2'h3) begin
                  word_ok_reg <= 1'b0;
                end
              end
              if (tx_idx_reg != 4'hf) begin
                tx_idx_reg <= tx_idx_reg + 4'h1;
              end
              sh_reg <= tx_byte;
              sda_oe <= ~tx_byte[7];
              scl_oe <= 1'b0;
              bit_cnt_reg <= 4'h0;
              state_reg <= ST_TX;
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bit_cnt_reg == 4'h7) begin
                sda_oe <= 1'b0;
                state_reg <= ST_MACK;
              end else begin
                sh_reg <= {sh_reg[6:0], 1'b1};
                sda_oe <= ~sh_reg[6];
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              nak_reg <= sda_s_reg;
            end
            if (scl_fall) begin
              if (nak_reg) begin
                state_reg <= ST_SKIP;
              end else begin
                state_reg <= ST_TXLD;
                scl_oe <= 1'b1;
              end
            end
          end
          ST_IDLE, ST_SKIP: begin
            sda_oe <= 1'b0;
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule // i2cpe_engine

`default_nettype wire

// ==== test/i2cpe_engine_sva.sv ====
`default_nettype none
module i2cpe_engine_chk #(
  parameter STRETCH_CYCLES = 50000
) (
  // Clock, reset
  input wire logic clk,
  input wire logic rst,
  // Bus
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_o,
  input wire logic sda_oe,
  // Events
  input wire logic start_pend,
  input wire logic start_svc,
  input wire logic rx_pend,
  input wire logic rx_svc,
  input wire logic rd_req,
  input wire logic rd_load,
  // Memory
  input wire logic mem_wr_en,
  input wire logic [19:0] mem_wr_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  int hold;
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (rst);
  // One cycle of slack on the limit
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      hold <= 0;
    end else begin
      hold <= scl_oe ? hold + 1 : 0;
    end
  end
  property p_open_drain;
    !scl_o && !sda_o;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("pin driven high");
  property p_start_hold;
    start_pend |-> scl_oe;
  endproperty
  a_start_hold: assert property (p_start_hold)
    else $error("start not stretched");
  property p_start_svc;
    start_pend && start_svc && !rx_pend |=> !start_pend ##1 (!scl_oe && sda_oe);
  endproperty
  a_start_svc: assert property (p_start_svc)
    else $error("start service");
  property p_rx_svc;
    rx_pend && rx_svc |=> !rx_pend;
  endproperty
  a_rx_svc: assert property (p_rx_svc)
    else $error("rx service");
  property p_order;
    start_pend && rx_pend && start_svc && hold < STRETCH_CYCLES - 2 |=> start_pend;
  endproperty
  a_order: assert property (p_order)
    else $error("start serviced before receive");
  property p_rd_hold;
    rd_req |-> scl_oe;
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("empty tx not stretched");
  property p_rd_load;
    rd_req && rd_load |=> !rd_req ##1 !scl_oe;
  endproperty
  a_rd_load: assert property (p_rd_load)
    else $error("tx load");
  property p_limit;
    hold > STRETCH_CYCLES |-> !scl_oe && !start_pend && !rd_req;
  endproperty
  a_limit: assert property (p_limit)
    else $error("stretch too long");
  property p_wr2;
    mem_wr_en && $past(mem_wr_en) |-> mem_wr_addr == $past(mem_wr_addr) + 20'h2;
  endproperty
  a_wr2: assert property (p_wr2)
    else $error("second word address");
  property p_wr3;
    mem_wr_en ##1 mem_wr_en |=> !mem_wr_en;
  endproperty
  a_wr3: assert property (p_wr3)
    else $error("too many words");
endmodule // i2cpe_engine_chk
bind i2cpe_engine i2cpe_engine_chk #(.STRETCH_CYCLES(STRETCH_CYCLES)) u_chk (
  .clk(clk), .rst(rst), .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe),
  .start_pend(start_pend), .start_svc(start_svc), .rx_pend(rx_pend), .rx_svc(rx_svc),
  .rd_req(rd_req), .rd_load(rd_load), .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr)
);
`default_nettype wire

// ==== test/i2cpe_ctrl_model.sv ====
`default_nettype none
module i2cpe_ctrl_model (
  // Wire levels
  input wire logic scl,
  input wire logic sda,
  // Pull-downs
  output logic scl_dn,
  output logic sda_dn
);
  timeunit 1ns;
  timeprecision 1ns;
  int waited;
  initial begin
    scl_dn = 0;
    sda_dn = 0;
  end
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      c = (c[7] ^ d[i]) ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    end
    return c;
  endfunction
  task automatic hi();
    scl_dn = 0;
    for (waited = 0; waited < 400 && scl !== 1'b1; waited++) begin
      #100;
    end
    #400;
  endtask
  // Data moves only while SCL low
  task automatic bit_io(input logic b, output logic r);
    #100;
    sda_dn = !b;
    #300;
    hi();
    r = sda;
    scl_dn = 1;
  endtask
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
                      output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(last, r);
    ack = !r;
  endtask
  // Also serves as repeated start
  task automatic start();
    #17;
    sda_dn = 0;
    #400;
    hi();
    sda_dn = 1;
    #400;
    scl_dn = 1;
  endtask
  task automatic stop();
    sda_dn = 1;
    #400;
    hi();
    sda_dn = 0;
    #400;
  endtask
endmodule // i2cpe_ctrl_model
`default_nettype wire

// ==== test/test_i2c_target_crc_packet_engine.sv ====
`default_nettype none
module test_i2c_target_crc_packet_engine;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0;
  logic rst = 1;
  logic start_svc = 0;
  logic rx_svc = 0;
  logic rd_load = 0;
  logic [31:0] rd_data = 32'h0;
  logic auto_svc = 1;
  logic rx_hold = 0;
  logic acks;
  logic [7:0] crc;
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [7:0] rxq[$];
  logic [19:0] waq[$];
  logic [31:0] wdq[$];
  wire scl_oe, sda_oe, scl_dn, sda_dn, start_pend, rx_pend, rd_req, mem_wr_en;
  wire [7:0] rx_byte;
  wire [19:0] rd_addr, mem_wr_addr;
  wire [31:0] mem_wr_data;
  // Pulled-up open-drain wires
  wire scl = !(scl_oe || scl_dn);
  wire sda = !(sda_oe || sda_dn);
  i2cpe_engine #(.STRETCH_CYCLES(200)) uut (
    .clk(clk), .rst(rst), .scl_i(scl), .scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(),
    .sda_oe(sda_oe), .start_pend(start_pend), .start_svc(start_svc), .rx_pend(rx_pend),
    .rx_byte(rx_byte), .rx_svc(rx_svc), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_data(rd_data), .rd_load(rd_load), .mem_wr_en(mem_wr_en),
    .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data)
  );
  i2cpe_ctrl_model m (.scl(scl), .sda(sda), .scl_dn(scl_dn), .sda_dn(sda_dn));
  always #50 clk = ~clk;
  // Service events; guards keep pulses one cycle
  always @(negedge clk) begin
    rx_svc <= auto_svc && !rx_hold && rx_pend && !rx_svc;
    start_svc <= auto_svc && start_pend && !start_svc;
    rd_load <= auto_svc && rd_req && !rd_load;
    rd_data <= 32'h1234abcd + {12'h0, rd_addr};
    if (auto_svc && !rx_hold && rx_pend && !rx_svc) begin
      rxq.push_back(rx_byte);
    end
    if (mem_wr_en === 1'b1) begin
      waq.push_back(mem_wr_addr);
      wdq.push_back(mem_wr_data);
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      fails++;
      $display("[FAIL] %0t run timed out", $time);
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // cm: 0 no code, 1 good code, 2 corrupted code
  task automatic pkt(input logic [7:0] q[$], input logic [1:0] cm, input logic stp);
    logic [7:0] r;
    logic a;
    acks = 1;
    crc = 8'hff;
    m.start();
    foreach (q[i]) begin
      m.xfer(q[i], 1'b1, r, a);
      acks &= a;
      crc = m.crc8(crc, q[i]);
    end
    if (cm != 2'd0) m.xfer(crc ^ {7'h0, cm[1]}, 1'b1, r, a);
    acks &= a;
    if (stp) m.stop();
    repeat (8) @(negedge clk);
  endtask
  task automatic t_wr32();
    rxq.delete();
    waq.delete();
    wdq.delete();
    pkt('{8'hc0, 8'h50, 8'h00, 8'h80, 8'hcd, 8'hab, 8'h34, 8'h12}, 2'd1, 1'b1);
    chk(acks, 1);
    chk(rxq.size(), 8);
    chk(rxq[0], 8'h50);
    chk(waq[0], 20'h00080);
    chk(wdq[0], 32'h1234abcd);
    $display("wr32 end");
  endtask
  task automatic t_wr64();
    waq.delete();
    wdq.delete();
    pkt('{8'hc0, 8'h60, 8'h00, 8'h80, 8'h01, 8'h23, 8'h45, 8'h67, 8'h89, 8'hab, 8'hcd,
          8'hef}, 2'd1, 1'b1);
    chk(waq.size(), 2);
    chk(waq[1], 20'h00082);
    chk(wdq[0], 32'h67452301);
    chk(wdq[1], 32'hefcdab89);
    $display("wr64 end");
  endtask
  task automatic t_wr16();
    waq.delete();
    wdq.delete();
    pkt('{8'hc0, 8'h05, 8'ha1, 8'h23, 8'hef, 8'hbe}, 2'd0, 1'b1);
    chk(waq[0], 20'h5a123);
    chk(wdq[0], 32'h0000beef);
    $display("wr16 end");
  endtask
  task automatic t_drop();
    waq.delete();
    pkt('{8'hc0, 8'h50, 8'h00, 8'h80, 8'hcd, 8'hab, 8'h34, 8'h12}, 2'd2, 1'b1);
    pkt('{8'hc0, 8'h00, 8'h00, 8'h80, 8'h11, 8'h22, 8'h33}, 2'd0, 1'b1);
    pkt('{8'hc0, 8'h30, 8'h00, 8'h80, 8'h11, 8'h22, 8'h33, 8'h44}, 2'd0, 1'b1);
    chk(waq.size(), 0);
    $display("drop end");
  endtask
  task automatic t_foreign();
    rxq.delete();
    waq.delete();
    pkt('{8'hc2, 8'h00, 8'h00, 8'h80, 8'h11, 8'h22}, 2'd0, 1'b1);
    chk(acks, 0);
    chk(rxq.size() + waq.size(), 0);
    $display("foreign end");
  endtask
  task automatic t_read(input logic [1:0] len);
    logic [7:0] r;
    logic a;
    logic [63:0] d;
    d = {32'h1234abcd + 32'h82, 32'h1234abcd + 32'h80};
    pkt('{8'hc0, {2'b11, len, 4'h0}, 8'h00, 8'h80}, 2'd0, 1'b0);
    m.start();
    m.xfer(8'hc1, 1'b1, r, a);
    chk(a, 1);
    crc = m.crc8(crc, 8'hc1);
    for (int i = 0; i <= (2 << len); i++) begin
      m.xfer(8'hff, i == (2 << len), r, a);
      if (i == (2 << len)) begin
        chk(r, crc);
      end else begin
        chk(r, d[8*i +: 8]);
        crc = m.crc8(crc, r);
      end
    end
    m.stop();
    $display("read end");
  endtask
  task automatic t_order();
    logic [7:0] r;
    logic a;
    rx_hold = 1;
    pkt('{8'hc0, 8'h00}, 2'd0, 1'b0);
    fork
      begin
        m.start();
        m.xfer(8'hc0, 1'b1, r, a);
      end
      begin
        repeat (120) @(negedge clk);
        chk(start_pend, 1);
        chk(rx_pend, 1);
        rx_hold = 0;
      end
    join
    chk(a, 1);
    m.stop();
    $display("order end");
  endtask
  task automatic t_stretch();
    logic [7:0] r;
    logic a;
    waq.delete();
    auto_svc = 0;
    fork
      begin
        m.start();
        m.xfer(8'hc0, 1'b1, r, a);
      end
      begin
        repeat (120) @(negedge clk);
        chk(start_pend, 1);
        chk(scl, 0);
        auto_svc = 1;
      end
    join
    chk(a, 1);
    rx_hold = 1;
    m.xfer(8'h00, 1'b1, r, a);
    fork
      m.xfer(8'h00, 1'b1, r, a);
      begin
        repeat (110) @(negedge clk);
        chk(rx_pend, 1);
        chk(scl, 0);
        rx_hold = 0;
      end
    join
    m.stop();
    repeat (8) @(negedge clk);
    chk(waq.size(), 0);
    $display("stretch end");
  endtask
  task automatic t_timeout();
    logic [7:0] r;
    logic a;
    auto_svc = 0;
    m.start();
    m.xfer(8'hc0, 1'b1, r, a);
    chk(a, 0);
    chk(m.waited >= 180 && m.waited <= 205, 1);
    chk(start_pend, 0);
    auto_svc = 1;
    m.stop();
    $display("timeout end");
  endtask
  initial begin
    repeat (5) @(negedge clk);
    rst = 0;
    repeat (5) @(negedge clk);
    t_wr32();
    t_wr64();
    t_wr16();
    t_drop();
    t_foreign();
    for (int l = 0; l < 3; l++) t_read(l[1:0]);
    t_order();
    t_stretch();
    t_timeout();
    t_wr16();
    test_done();
  end
endmodule // test_i2c_target_crc_packet_engine
`default_nettype wire
